// File: logic/mgmt_map.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  PHY management port. Assumes a 10 MHz core clock and full 32-bit addressing.
*/
`ifndef MGMT_MAP_SVH
`define MGMT_MAP_SVH

`define MGMT_COMMAND_ADDR     32'hFF800540
`define MGMT_PHY_SELECT_ADDR  32'hFF800544
`define MGMT_WRITE_VALUE_ADDR 32'hFF800548
`define MGMT_READ_VALUE_ADDR  32'hFF80054C
`define MGMT_INDICATORS_ADDR  32'hFF800550

`define CMD_READ_BIT     0
`define CMD_SCAN_BIT     1
`define REG_SELECT_LSB   0
`define PHY_SELECT_LSB   8
`define IND_BUSY_BIT     0
`define IND_SCAN_BIT     1

`define SELECT_RESET     5'h00
`define VALUE_RESET      16'h0000

`define CORE_PERIOD_NS   100
`define MDC_PERIOD_NS    800
`define MDC_HALF_CYCLES  (`MDC_PERIOD_NS / (2 * `CORE_PERIOD_NS))

`define FRAME_BITS       64
`define FRAME_TA_BIT     46
`define FRAME_DATA_BIT   48
`define FRAME_LAST_BIT   63

`endif

// File: logic/mgmt_pkg.sv
/*
  Types shared by the PHY management port modules.
  Assumes mgmt_map.svh supplies numeric constants.
*/
package mgmt_pkg;

  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b00,
    ENG_SHIFT = 2'b01,
    ENG_DONE  = 2'b11
  } eng_state_t;

  typedef logic [4:0]  sel5_t;
  typedef logic [15:0] word16_t;

endpackage

// File: logic/mgmt_clk_if.sv
/*
  Carrier between the frame engine and the management clock generator.
  Assumes both ends share core_clk.
*/
`timescale 1ns/1ns
interface mgmt_clk_if;
  logic run;
  logic rise_tick;
  logic fall_tick;
  logic mdc;

  modport gen (input run, output rise_tick, output fall_tick, output mdc);
  modport eng (output run, input rise_tick, input fall_tick, input mdc);
endinterface

// File: logic/mgmt_clk_gen.sv
/*
  Management clock divider: derives the link clock from core_clk and gives
  one-cycle enables on its rising and falling edges. Assumes synchronous reset.
*/
`timescale 1ns/1ns
`include "mgmt_map.svh"
module mgmt_clk_gen
  import mgmt_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  mgmt_clk_if.gen   lnk
);

  localparam logic [3:0] HALF_LAST = 4'(`MDC_HALF_CYCLES - 1);

  logic [3:0] cnt_ff;
  logic       mdc_ff;
  logic       rise_ff;
  logic       fall_ff;

  // half-period counter, idle low
  always_ff @(posedge core_clk) begin
    if (rst || !lnk.run) begin
      cnt_ff  <= 4'h0;
      mdc_ff  <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else if (cnt_ff == HALF_LAST) begin
      cnt_ff  <= 4'h0;
      mdc_ff  <= !mdc_ff;
      rise_ff <= !mdc_ff;
      fall_ff <= mdc_ff;
    end else begin
      cnt_ff  <= cnt_ff + 4'h1;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end
  end

  assign lnk.mdc       = mdc_ff;
  assign lnk.rise_tick = rise_ff;
  assign lnk.fall_tick = fall_ff;

endmodule

// File: logic/phy_management_port.sv
/*
  PHY management port: register file on a plain strobe port and the serial
  frame engine for the management clock and data lines.
  Assumes a 10 MHz core_clk, synchronous active-high rst, and an external
  wire resolving mdio from mdio_out and mdio_oe.
*/
// Local design decision: the plain strobed port.
//
// Contract
// - Hold 5-bit PHY device address, reset zero; zero is reserved.
// - Hold 5-bit PHY register address, reset zero, selecting one of 32.
// - Writing the write-value register launches a write of that 16-bit value.
// - After a read completes, read-value register returns the PHY data.
// - Busy is 1 throughout a read or write cycle, 0 when done; frames started by scan leave it 0.
// - Scan indicator is 1 while continuous repeated reads run.
`timescale 1ns/1ns
`include "mgmt_map.svh"
module phy_management_port
  import mgmt_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  output logic             mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe
);

  function automatic logic [63:0] build_frame(input logic    is_read,
                                              input sel5_t   phy,
                                              input sel5_t   regs,
                                              input word16_t data);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 2'b01, (is_read ? 2'b10 : 2'b01), phy, regs, 2'b10,
         (is_read ? 16'h0000 : data)};
    return f;
  endfunction

  mgmt_clk_if lnk ();

  mgmt_clk_gen u_clk_gen (
    .core_clk (core_clk),
    .rst      (rst),
    .lnk      (lnk)
  );

  sel5_t       phy_sel_ff;
  sel5_t       reg_sel_ff;
  word16_t     wval_ff;
  word16_t     rval_ff;
  logic        wr_pend_ff;
  logic        rd_pend_ff;
  logic        scan_en_ff;
  logic [31:0] rdata_ff;
  logic        sync1_ff;
  logic        sync2_ff;
  eng_state_t  state_ff;
  logic [5:0]  bit_cnt_ff;
  logic [63:0] shift_ff;
  word16_t     rd_shift_ff;
  logic        op_read_ff;
  logic        op_scan_ff;
  logic        out_ff;
  logic        oe_ff;
  logic        mdc_ff;
  logic        start;
  logic        busy_now;
  logic        scan_now;
  logic        hit_cmd;
  logic        hit_wval;

  assign hit_cmd  = bus_wr && (bus_addr == `MGMT_COMMAND_ADDR);
  assign hit_wval = bus_wr && (bus_addr == `MGMT_WRITE_VALUE_ADDR);
  assign start    = (state_ff == ENG_IDLE) && (wr_pend_ff || rd_pend_ff || scan_en_ff);
  assign lnk.run  = (state_ff != ENG_IDLE);

  assign busy_now = wr_pend_ff || rd_pend_ff || (lnk.run && !op_scan_ff);
  assign scan_now = scan_en_ff || (lnk.run && op_scan_ff);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phy_sel_ff <= `SELECT_RESET;
      reg_sel_ff <= `SELECT_RESET;
    end else if (bus_wr && (bus_addr == `MGMT_PHY_SELECT_ADDR)) begin
      phy_sel_ff <= bus_wdata[`PHY_SELECT_LSB +: 5];
      reg_sel_ff <= bus_wdata[`REG_SELECT_LSB +: 5];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wval_ff    <= `VALUE_RESET;
      wr_pend_ff <= 1'b0;
    end else if (hit_wval) begin
      wval_ff    <= bus_wdata[15:0];
      wr_pend_ff <= 1'b1;
    end else if (start) begin
      wr_pend_ff <= 1'b0;
    end
  end

  // read request and scan enable
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_pend_ff <= 1'b0;
      scan_en_ff <= 1'b0;
    end else begin
      if (hit_cmd) begin
        scan_en_ff <= bus_wdata[`CMD_SCAN_BIT];
      end
      if (hit_cmd && bus_wdata[`CMD_READ_BIT]) begin
        rd_pend_ff <= 1'b1;
      end else if (start && !wr_pend_ff) begin
        rd_pend_ff <= 1'b0;
      end
    end
  end

  // read data mux, one cycle later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_ff <= 32'h00000000;
    end else if (bus_rd) begin
      case (bus_addr)
        `MGMT_COMMAND_ADDR:
          rdata_ff <= {30'h00000000, scan_en_ff, rd_pend_ff};
        `MGMT_PHY_SELECT_ADDR:
          rdata_ff <= {19'h00000, phy_sel_ff, 3'h0, reg_sel_ff};
        `MGMT_WRITE_VALUE_ADDR:
          rdata_ff <= {16'h0000, wval_ff};
        `MGMT_READ_VALUE_ADDR:
          rdata_ff <= {16'h0000, rval_ff};
        `MGMT_INDICATORS_ADDR:
          rdata_ff <= {30'h00000000, scan_now, busy_now};
        default:
          rdata_ff <= 32'h00000000;
      endcase
    end
  end

  // link data input synchroniser
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= mdio_in;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff    <= ENG_IDLE;
      bit_cnt_ff  <= 6'h00;
      shift_ff    <= 64'h0000000000000000;
      rd_shift_ff <= `VALUE_RESET;
      op_read_ff  <= 1'b0;
      op_scan_ff  <= 1'b0;
      out_ff      <= 1'b0;
      oe_ff       <= 1'b0;
    end else begin
      case (state_ff)
        ENG_IDLE: begin
          if (start) begin
            state_ff   <= ENG_SHIFT;
            bit_cnt_ff <= 6'h00;
            op_read_ff <= !wr_pend_ff;
            op_scan_ff <= !wr_pend_ff && !rd_pend_ff;
            shift_ff   <= build_frame(!wr_pend_ff, phy_sel_ff, reg_sel_ff, wval_ff);
            out_ff     <= 1'b1;
            oe_ff      <= 1'b1;
          end
        end
        ENG_SHIFT: begin
          if (lnk.rise_tick) begin
            if (op_read_ff && (bit_cnt_ff >= 6'(`FRAME_DATA_BIT))) begin
              rd_shift_ff <= {rd_shift_ff[14:0], sync2_ff};
            end
            if (bit_cnt_ff == 6'(`FRAME_LAST_BIT)) begin
              state_ff <= ENG_DONE;
            end
          end else if (lnk.fall_tick) begin
            bit_cnt_ff <= bit_cnt_ff + 6'h01;
            shift_ff   <= {shift_ff[62:0], 1'b0};
            out_ff     <= shift_ff[62];
            oe_ff      <= !(op_read_ff && (bit_cnt_ff >= 6'(`FRAME_TA_BIT - 1)));
          end
        end
        ENG_DONE: begin
          if (lnk.fall_tick) begin
            state_ff <= ENG_IDLE;
            out_ff   <= 1'b0;
            oe_ff    <= 1'b0;
          end
        end
        default: begin
          state_ff <= ENG_IDLE;
          oe_ff    <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rval_ff <= `VALUE_RESET;
    end else if ((state_ff == ENG_DONE) && lnk.fall_tick && op_read_ff) begin
      rval_ff <= rd_shift_ff;
    end
  end

  // link clock output register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mdc_ff <= 1'b0;
    end else begin
      mdc_ff <= lnk.mdc;
    end
  end

  assign bus_rdata = rdata_ff;
  assign mdc       = mdc_ff;
  assign mdio_out  = out_ff;
  assign mdio_oe   = oe_ff;

endmodule

// File: testbench/mgmt_phy_model.sv
/* behavioural phy on the management link, answering one device address.
   assumes the bench resolves the shared data wire with a pull-up. */
`timescale 1ns/1ns
module mgmt_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h13
) (
  input  wire logic mdc,
  input  wire logic mdio_wire,
  output logic      phy_oe,
  output logic      phy_bit
);
  logic [33:0] sh;
  logic [15:0] mem [32];
  logic [16:0] dsh;
  logic [4:0]  regs;
  logic        hit;
  logic        rd;
  int          n;
  initial begin
    phy_oe = 1'b0;
    phy_bit = 1'b1;
    rd = 1'b0;
    n = 0;
    sh = '0;
  end
  // frame decode on clock rise
  always @(posedge mdc) begin
    sh = {sh[32:0], mdio_wire};
    if (n == 0 && sh[3:0] == 4'hD) begin
      n = 2;
    end else if (n > 0) begin
      n = n + 1;
    end
    if (n == 15) begin
      hit = (sh[10:6] == PHY_ADDR);
      regs = sh[5:1];
      rd = hit && sh[12:11] == 2'b10;
      dsh = {1'b0, mem[sh[5:1]]};
    end
    if (n == 32) begin
      if (hit && !rd) begin
        mem[regs] = sh[15:0];
      end
      rd = 1'b0;
      n = 0;
      sh = '0;
    end
  end
  // turnaround low then data, msb first, changed on clock fall
  always @(negedge mdc) begin
    phy_oe = rd;
    phy_bit = dsh[16];
    dsh = {dsh[15:0], 1'b0};
  end
endmodule

// File: testbench/phy_management_port_checker.sv
/* assertions on the management port pins and register reads.
   assumes the top module ports and the mgmt_map.svh addresses. */
`timescale 1ns/1ns
`include "mgmt_map.svh"
module phy_management_port_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic        mdc,
  input wire logic        mdio_in,
  input wire logic        mdio_out,
  input wire logic        mdio_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_rdata_holds: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  chk_select_width: assert property (bus_rd && bus_addr == `MGMT_PHY_SELECT_ADDR
    |=> (bus_rdata & 32'hFFFFE0E0) == 32'h0) else $error("select has extra bits");
  chk_indicator_bits: assert property (bus_rd && bus_addr == `MGMT_INDICATORS_ADDR
    |=> bus_rdata[31:2] == 30'h0) else $error("indicators has extra bits");
  chk_write_launch: assert property (bus_wr && bus_addr == `MGMT_WRITE_VALUE_ADDR
    |-> ##[1:600] $rose(mdio_oe)) else $error("write frame not launched");
  chk_preamble_ones: assert property ($rose(mdio_oe) |-> mdio_out [*8])
    else $error("frame does not open with ones");
  chk_mdc_high: assert property ($rose(mdc) |=> mdc [*3])
    else $error("clock high phase short");
  chk_mdc_low: assert property ($fell(mdc) |=> !mdc [*3])
    else $error("clock low phase short");
  chk_out_steady: assert property (mdc && $past(mdc) && mdio_oe |-> $stable(mdio_out))
    else $error("data moved while clock high");
endmodule
bind phy_management_port phy_management_port_checker u_phy_management_port_checker (
  .core_clk(core_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .mdc(mdc),
  .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));

// File: testbench/phy_management_port_bench.sv
/* bench for the phy management port with a phy model on the link.
   assumes a pulled-up data wire and synchronous active-high reset. */
`timescale 1ns/1ns
`include "mgmt_map.svh"
module phy_management_port_bench;
  localparam logic [4:0] PHY_HERE = 5'h13;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] bus_addr = 32'h0;
  logic [31:0] bus_wdata = 32'h0;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  logic        mdc;
  logic        mdio_out;
  logic        mdio_oe;
  logic        phy_oe;
  logic        phy_bit;
  wire logic   mdio_in = mdio_oe ? mdio_out : (phy_oe ? phy_bit : 1'b1);
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #50 core_clk = ~core_clk;
  phy_management_port u_phy_management_port (.core_clk(core_clk), .rst(rst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe));
  mgmt_phy_model #(.PHY_ADDR(PHY_HERE)) u_mgmt_phy_model (.mdc(mdc), .mdio_wire(mdio_in),
    .phy_oe(phy_oe), .phy_bit(phy_bit));
  function automatic logic [31:0] sel(input logic [4:0] p, input logic [4:0] r);
    return {19'h0, p, 3'h0, r};
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask
  task automatic expect_reg(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] seen;
    bus_read(a, seen);
    samples_checked++;
    if (seen !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic wait_idle;
    logic [31:0] ind;
    int          polls;
    ind = 32'h1;
    polls = 0;
    while (ind[`IND_BUSY_BIT] !== 1'b0 && polls < 600) begin
      bus_read(`MGMT_INDICATORS_ADDR, ind);
      polls++;
    end
    samples_checked++;
    if (ind[`IND_BUSY_BIT] !== 1'b0) begin
      mismatches++;
      $display("Error busy expected 0 seen %b", ind[`IND_BUSY_BIT]);
    end
  endtask
  task automatic test_reset;
    expect_reg("select", `MGMT_PHY_SELECT_ADDR, 32'h0);
    expect_reg("indicators", `MGMT_INDICATORS_ADDR, 32'h0);
    expect_reg("read value", `MGMT_READ_VALUE_ADDR, 32'h0);
    expect_reg("unmapped", 32'hFF800554, 32'h0);
    $display("test reset done");
  endtask
  task automatic test_write_read;
    bus_write(`MGMT_PHY_SELECT_ADDR, sel(PHY_HERE, 5'h1F));
    expect_reg("select", `MGMT_PHY_SELECT_ADDR, sel(PHY_HERE, 5'h1F));
    bus_write(`MGMT_WRITE_VALUE_ADDR, 32'h0000A5C3);
    expect_reg("busy write", `MGMT_INDICATORS_ADDR, 32'h1);
    wait_idle;
    samples_checked++;
    if (u_mgmt_phy_model.mem[31] !== 16'hA5C3) begin
      mismatches++;
      $display("Error phy register expected a5c3 seen %h", u_mgmt_phy_model.mem[31]);
    end
    bus_write(`MGMT_COMMAND_ADDR, 32'h1);
    expect_reg("busy read", `MGMT_INDICATORS_ADDR, 32'h1);
    wait_idle;
    expect_reg("read value", `MGMT_READ_VALUE_ADDR, 32'h0000A5C3);
    $display("test write read done");
  endtask
  task automatic test_absent_phy;
    bus_write(`MGMT_PHY_SELECT_ADDR, sel(5'h02, 5'h1F));
    bus_write(`MGMT_COMMAND_ADDR, 32'h1);
    wait_idle;
    expect_reg("absent phy", `MGMT_READ_VALUE_ADDR, 32'h0000FFFF);
    $display("test absent phy done");
  endtask
  task automatic test_scan;
    bus_write(`MGMT_PHY_SELECT_ADDR, sel(PHY_HERE, 5'h00));
    bus_write(`MGMT_WRITE_VALUE_ADDR, 32'h00003C5A);
    wait_idle;
    bus_write(`MGMT_COMMAND_ADDR, 32'h2);
    expect_reg("scan on", `MGMT_INDICATORS_ADDR, 32'h2);
    repeat (1200) @(posedge core_clk);
    expect_reg("scan value", `MGMT_READ_VALUE_ADDR, 32'h00003C5A);
    bus_write(`MGMT_COMMAND_ADDR, 32'h0);
    repeat (600) @(posedge core_clk);
    expect_reg("scan off", `MGMT_INDICATORS_ADDR, 32'h0);
    $display("test scan done");
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      mismatches++;
      complete_run;
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    test_reset;
    test_write_read;
    test_absent_phy;
    test_scan;
    complete_run;
  end
endmodule
